// ### rtl/dcst_regs.sv
// Purpose: DSP configuration and self-test register bank
// Assumes: Register port from the serial interface, one-cycle write strobe
// Notes:   Slot one is loaded from datapath inputs, test patterns or digital test outputs
`timescale 1ns/10ps
module dcst_regs
  import dcst_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        dsp_valid,
  input  wire logic [15:0] dsp_pressure,
  input  wire logic [15:0] dsp_temp,
  input  wire logic [15:0] dst_out [4],
  input  wire logic        int_event,
  output logic             int_pin_o,
  output logic             int_pin_oe,
  output logic             dsp_restart,
  output logic             dsp_busy,
  output logic      [7:0]  slot_one_low_byte,
  output logic      [7:0]  slot_one_high_byte,
  output logic      [7:0]  crc_image,
  output logic      [3:0]  lowpass_select
);
  // ==========================================================================
  // Registers
  logic [7:0]  type_q, type_d, pin_q, pin_d, st_q, st_d, lpf_q, lpf_d;
  logic [4:0]  init_q, init_d;
  logic [15:0] slot_q, slot_d;
  logic        rst_q, rst_d;
  logic [3:0]  test_function_sel;
  logic [1:0]  slot_one_type_sel;
  dcst_src_t   src;

  function automatic logic [15:0] pattern(input logic [1:0] c);
    case (c)
      2'h0:    pattern = DCST_PAT_ZERO;
      2'h1:    pattern = DCST_PAT_AAAA;
      2'h2:    pattern = DCST_PAT_5555;
      default: pattern = DCST_PAT_FFFF;
    endcase
  endfunction : pattern

  assign test_function_sel = st_q[DCST_TEST_LSB +: 4];
  assign slot_one_type_sel = type_q[DCST_SLOT1_LSB +: 2];

  always_comb begin
    case (test_function_sel[3:2])
      2'h0:    src = (test_function_sel[1]) ? DCST_SRC_RESV : DCST_SRC_NORMAL;
      2'h1:    src = DCST_SRC_PATTERN;
      2'h3:    src = DCST_SRC_DIGITAL;
      default: src = DCST_SRC_RESV;
    endcase
  end

  // ==========================================================================
  // Register writes and datapath restart
  always_comb begin
    type_d = type_q;
    pin_d  = pin_q;
    st_d   = st_q;
    lpf_d  = lpf_q;
    rst_d  = 1'b0;
    init_d = (init_q != 5'h00) ? init_q - 5'h01 : init_q;
    if (reg_wr) begin
      case (reg_addr)
        DCST_ADDR_TYPE_SEL: begin
          type_d = reg_wdata;
          if (reg_wdata != type_q) begin
            rst_d  = 1'b1;
            init_d = 5'(DCST_INIT_CYCLES);
          end
        end
        DCST_ADDR_INT_PIN:   pin_d = reg_wdata;
        DCST_ADDR_SELF_TEST: st_d  = reg_wdata;
        DCST_ADDR_LPF:       lpf_d = reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      type_q <= DCST_RST_TYPE_SEL;
      pin_q  <= DCST_RST_INT_PIN;
      st_q   <= DCST_RST_SELF_TEST;
      lpf_q  <= DCST_RST_LPF;
      rst_q  <= 1'b0;
      init_q <= 5'h00;
    end else begin
      type_q <= type_d;
      pin_q  <= pin_d;
      st_q   <= st_d;
      lpf_q  <= lpf_d;
      rst_q  <= rst_d;
      init_q <= init_d;
    end
  end

  // ==========================================================================
  // Slot one contents
  always_comb begin
    slot_d = slot_q;
    case (src)
      DCST_SRC_PATTERN: slot_d = pattern(test_function_sel[1:0]);
      DCST_SRC_DIGITAL: slot_d = dst_out[test_function_sel[1:0]];
      DCST_SRC_NORMAL: begin
        if (dsp_valid && init_q == 5'h00) begin
          if (slot_one_type_sel == DCST_TYPE_PRESSURE)
            slot_d = dsp_pressure;
          else if (slot_one_type_sel == DCST_TYPE_TEMP)
            slot_d = dsp_temp;
        end
      end
      default: slot_d = slot_q;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) slot_q <= DCST_PAT_ZERO;
    else        slot_q <= slot_d;
  end

  // ==========================================================================
  // Outputs
  always_comb begin
    case (reg_addr)
      DCST_ADDR_TYPE_SEL:  reg_rdata = type_q;
      DCST_ADDR_INT_PIN:   reg_rdata = pin_q;
      DCST_ADDR_SELF_TEST: reg_rdata = st_q;
      DCST_ADDR_LPF:       reg_rdata = lpf_q;
      default:             reg_rdata = 8'h00;
    endcase
  end

  // Driven only while int_event is set: drive the active level, high or low per the polarity bit
  assign int_pin_o  = ~pin_q[DCST_INT_OUT_BIT];
  assign int_pin_oe = int_event;
  assign dsp_restart = rst_q;
  assign dsp_busy    = (init_q != 5'h00);
  assign slot_one_low_byte  = slot_q[7:0];
  assign slot_one_high_byte = slot_q[15:8];
  assign lowpass_select     = lpf_q[7:4];
  // Error-check image: self-test field masked out
  assign crc_image = type_q ^ lpf_q ^ pin_q
                     ^ (st_q & DCST_SELF_TEST_CRC_MASK);

  // ==========================================================================
  // Assertions
  a_pattern_zero: assert property (
    @(posedge clock) disable iff (!rst_b)
    (test_function_sel == 4'h4) |=> (slot_q == DCST_PAT_ZERO))
    else $error("zero pattern not forced");
  a_pattern_force: assert property (
    @(posedge clock) disable iff (!rst_b)
    (test_function_sel == 4'h5) |=> (slot_q == DCST_PAT_AAAA))
    else $error("pattern not forced");
  a_pattern_fives: assert property (
    @(posedge clock) disable iff (!rst_b)
    (test_function_sel == 4'h6) |=> (slot_q == DCST_PAT_5555))
    else $error("fives pattern not forced");
  a_pattern_ones: assert property (
    @(posedge clock) disable iff (!rst_b)
    (test_function_sel == 4'h7) |=> (slot_q == DCST_PAT_FFFF))
    else $error("ones pattern not forced");
  a_temp_select: assert property (
    @(posedge clock) disable iff (!rst_b)
    (src == DCST_SRC_NORMAL && dsp_valid && !dsp_busy
     && slot_one_type_sel == DCST_TYPE_TEMP)
    |=> (slot_q == $past(dsp_temp)))
    else $error("temperature not loaded");
  a_press_select: assert property (
    @(posedge clock) disable iff (!rst_b)
    (test_function_sel[3:1] == 3'h0 && dsp_valid && !dsp_busy
     && slot_one_type_sel == DCST_TYPE_PRESSURE)
    |=> (slot_q == $past(dsp_pressure)))
    else $error("pressure not loaded");
  a_restart_busy: assert property (
    @(posedge clock) disable iff (!rst_b)
    dsp_restart |-> dsp_busy [*8])
    else $error("restart without busy window");
  a_busy_hold: assert property (
    @(posedge clock) disable iff (!rst_b)
    (src == DCST_SRC_NORMAL && dsp_busy) |=> $stable(slot_q))
    else $error("sample taken during restart");
  a_digital_out: assert property (
    @(posedge clock) disable iff (!rst_b)
    (test_function_sel == 4'hE) |=> (slot_q == $past(dst_out[2])))
    else $error("digital test output missing");
  a_pin_high: assert property (
    @(posedge clock) disable iff (!rst_b)
    (!pin_q[DCST_INT_OUT_BIT] && int_event) |-> (int_pin_oe && int_pin_o))
    else $error("active high drive wrong");
  a_pin_low: assert property (
    @(posedge clock) disable iff (!rst_b)
    (pin_q[DCST_INT_OUT_BIT] && int_event) |-> (int_pin_oe && !int_pin_o))
    else $error("active low drive wrong");
  a_pin_idle: assert property (
    @(posedge clock) disable iff (!rst_b)
    !int_event |-> !int_pin_oe)
    else $error("pin driven while idle");
  a_crc_mask: assert property (
    @(posedge clock) disable iff (!rst_b)
    $changed(st_q[7:4]) && $stable(st_q[3:0]) && $stable(type_q)
    && $stable(pin_q) && $stable(lpf_q) |-> $stable(crc_image))
    else $error("test field in error image");
  c_pattern: cover property (@(posedge clock) src == DCST_SRC_PATTERN);
  c_digital: cover property (@(posedge clock) src == DCST_SRC_DIGITAL);
  c_restart: cover property (@(posedge clock) dsp_restart);
  c_temp_load: cover property (@(posedge clock)
    src == DCST_SRC_NORMAL && dsp_valid && !dsp_busy
    && slot_one_type_sel == DCST_TYPE_TEMP);
  c_busy_drop: cover property (@(posedge clock) dsp_valid && dsp_busy);
endmodule : dcst_regs

// ### rtl/dcst_pkg.sv
// Purpose: Constants for the DSP configuration and self-test register bank
// Assumes: Byte-wide register port, addresses as printed
// Notes:   Shared by the design and the bench
package dcst_pkg;
  // ==========================================================================
  // Register addresses
  localparam logic [7:0] DCST_ADDR_TYPE_SEL  = 8'h42;
  localparam logic [7:0] DCST_ADDR_INT_PIN   = 8'h43;
  localparam logic [7:0] DCST_ADDR_SELF_TEST = 8'h44;
  localparam logic [7:0] DCST_ADDR_LPF       = 8'h40;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] DCST_RST_TYPE_SEL  = 8'h00;
  localparam logic [7:0] DCST_RST_INT_PIN   = 8'h00;
  localparam logic [7:0] DCST_RST_SELF_TEST = 8'h00;
  localparam logic [7:0] DCST_RST_LPF       = 8'h30;
  // ==========================================================================
  // Field positions
  localparam int DCST_SLOT1_LSB   = 2;
  localparam int DCST_INT_OUT_BIT = 2;
  localparam int DCST_TEST_LSB    = 4;
  localparam logic [7:0] DCST_SELF_TEST_CRC_MASK = 8'h0F;
  // ==========================================================================
  // Slot one type codes
  localparam logic [1:0] DCST_TYPE_PRESSURE = 2'h1;
  localparam logic [1:0] DCST_TYPE_TEMP     = 2'h3;
  // ==========================================================================
  // Test patterns
  localparam logic [15:0] DCST_PAT_ZERO = 16'h0000;
  localparam logic [15:0] DCST_PAT_AAAA = 16'hAAAA;
  localparam logic [15:0] DCST_PAT_5555 = 16'h5555;
  localparam logic [15:0] DCST_PAT_FFFF = 16'hFFFF;
  // ==========================================================================
  // Datapath restart time after a selector change
  localparam int DCST_INIT_CYCLES = 16;
  // ==========================================================================
  // Output source states
  typedef enum logic [3:0] {
    DCST_SRC_NORMAL  = 4'b0001,
    DCST_SRC_PATTERN = 4'b0010,
    DCST_SRC_DIGITAL = 4'b0100,
    DCST_SRC_RESV    = 4'b1000
  } dcst_src_t;
endpackage : dcst_pkg

// ### test/dcst_host.sv
// Purpose: Host controller model on the register port
// Assumes: Writes take one clock, reads are combinational
// Notes:   Data lines show the inverse of the last value when idle
`timescale 1ns/10ps
module dcst_host (
  input  wire logic       clock,
  output logic            reg_wr,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // ==========================================================================
  // Access tasks, launched at the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    #1 d = reg_rdata;
  endtask : rd
endmodule : dcst_host

// ### test/tb_top.sv
// Purpose: Self-checking bench for the configuration and self-test bank
// Assumes: Inputs change at the falling edge
// Notes:   Expected values come from fixed tables in this file
`timescale 1ns/10ps
module tb_top;
  import dcst_pkg::*;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        reg_wr, dsp_valid = 1'b0, int_event = 1'b0;
  logic        int_pin_o, int_pin_oe, dsp_restart, dsp_busy;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, lo, hi, crc_image, v;
  logic [3:0]  lowpass_select;
  logic [15:0] dsp_pressure = 16'h1234;
  logic [15:0] dsp_temp     = 16'h0F0E;
  logic [15:0] dst [4] = '{16'h1C1C, 16'h2D2D, 16'h3E3E, 16'h4F4F};
  logic [15:0] pat [4] = '{16'h0000, 16'hAAAA, 16'h5555, 16'hFFFF};
  int          n_fail = 0, checked = 0, cyc = 0;
  always #50 clock = ~clock;
  dcst_host i_host (.clock(clock), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  dcst_regs i_dut (.clock(clock), .rst_b(rst_b), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .dsp_valid(dsp_valid), .dsp_pressure(dsp_pressure),
    .dsp_temp(dsp_temp), .dst_out(dst), .int_event(int_event),
    .int_pin_o(int_pin_o), .int_pin_oe(int_pin_oe),
    .dsp_restart(dsp_restart), .dsp_busy(dsp_busy),
    .slot_one_low_byte(lo), .slot_one_high_byte(hi),
    .crc_image(crc_image), .lowpass_select(lowpass_select));
  // ==========================================================================
  // Checking helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    i_host.rd(a, v);
    chk({8'h00, v}, {8'h00, exp});
  endtask : rdc
  task automatic sample(input logic [4:0] wait_n);
    repeat (wait_n) @(negedge clock);
    dsp_valid = 1'b1;
    @(negedge clock);
    dsp_valid = 1'b0;
    @(negedge clock);
  endtask : sample
  task automatic give_verdict;
    if (n_fail == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  always @(posedge clock) begin
    cyc++;
    if (cyc == 1000) begin
      n_fail++;
      give_verdict();
    end
  end
  // ==========================================================================
  // Scenarios
  initial begin
    logic [3:0] c;
    repeat (3) @(negedge clock);
    rst_b = 1'b1;
    rdc(DCST_ADDR_LPF, 8'h30);
    chk({12'h000, lowpass_select}, 16'h0003);
    rdc(DCST_ADDR_INT_PIN, 8'h00);
    rdc(DCST_ADDR_SELF_TEST, 8'h00);
    rdc(8'h41, 8'h00);
    @(negedge clock);
    int_event = 1'b1;
    i_host.wr(DCST_ADDR_INT_PIN, 8'h04);
    chk({14'h0, int_pin_o, int_pin_oe}, 16'h0001);
    chk({8'h00, crc_image}, 16'h0034);
    i_host.wr(DCST_ADDR_INT_PIN, 8'h00);
    chk({14'h0, int_pin_o, int_pin_oe}, 16'h0003);
    dsp_valid = 1'b1;
    for (int i = 3; i >= 0; i--) begin
      c = 4'(i + 4);
      i_host.wr(DCST_ADDR_SELF_TEST, {c, 4'h0});
      @(negedge clock);
      chk({hi, lo}, pat[i]);
      chk({8'h00, crc_image}, 16'h0030);
    end
    for (int i = 0; i < 4; i++) begin
      c = 4'(i + 12);
      i_host.wr(DCST_ADDR_SELF_TEST, {c, 4'h0});
      @(negedge clock);
      chk({hi, lo}, dst[i]);
    end
    dsp_valid = 1'b0;
    i_host.wr(DCST_ADDR_SELF_TEST, 8'h00);
    i_host.wr(DCST_ADDR_TYPE_SEL, 8'h04);
    chk({14'h0, dsp_restart, dsp_busy}, 16'h0003);
    repeat (16) @(negedge clock);
    chk({14'h0, dsp_restart, dsp_busy}, 16'h0000);
    sample(5'h00);
    chk({hi, lo}, 16'h1234);
    i_host.wr(DCST_ADDR_SELF_TEST, 8'h10);
    dsp_pressure = 16'h8765;
    sample(5'h00);
    chk({hi, lo}, 16'h8765);
    chk({8'h00, crc_image}, 16'h0034);
    i_host.wr(DCST_ADDR_SELF_TEST, 8'h00);
    i_host.wr(DCST_ADDR_TYPE_SEL, 8'h0C);
    sample(5'h00);
    chk({hi, lo}, 16'h8765);
    sample(5'h0E);
    chk({hi, lo}, 16'h0F0E);
    rdc(DCST_ADDR_TYPE_SEL, 8'h0C);
    @(negedge clock);
    int_event = 1'b0;
    @(negedge clock);
    chk({14'h0, int_pin_o, int_pin_oe}, 16'h0002);
    i_host.wr(DCST_ADDR_LPF, 8'h20);
    rdc(DCST_ADDR_LPF, 8'h20);
    chk({12'h000, lowpass_select}, 16'h0002);
    @(negedge clock);
    rst_b = 1'b0;
    @(negedge clock);
    rst_b = 1'b1;
    rdc(DCST_ADDR_LPF, 8'h30);
    chk({12'h000, lowpass_select}, 16'h0003);
    give_verdict();
  end
endmodule : tb_top
